// >>> rtl/osirq_apb_slave.sv
// osirq_apb_slave: APB decode into one-cycle read and write strobes
// assumes the main block registers its read data during the wait state
`timescale 1ns/1ps
module osirq_apb_slave
    import osirq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    output logic pready,
    output logic slverr,
    output logic wrStb,
    output logic rdStb,
    output logic [ADDR_W-1:0] regAddr,
    input wire logic addrValid
);
    // one wait state keeps pready registered; strobes fire at the completing edge
    logic waited;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            waited <= 1'b0;
        end else begin
            waited <= psel && penable && !waited;
        end
    end
    assign pready = waited;
    assign slverr = waited && !addrValid;
    assign regAddr = paddr[ADDR_W-1:0];
    assign wrStb = psel && penable && waited && pwrite && addrValid;
    assign rdStb = psel && penable && waited && !pwrite && addrValid;
endmodule

// >>> rtl/osirq_pkg.sv
// osirq_pkg: register map, field positions and timing for the sensor irq block
// assumes a 200 MHz sys_clk and an APB register bus with 32-bit data
package osirq_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PROX_THRESH = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_MODE_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_FIFO_DATA = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_TEMP_DATA = 8'h18;
    localparam logic [7:0] EVENT_FLAGS_RST = 8'h00;
    localparam logic [7:0] INT_MASK_RST = 8'h00;
    localparam logic [3:0] CONTROL_RST = 4'h0;
    localparam logic [7:0] PROX_THRESH_RST = 8'h00;
    // event flag positions
    localparam int BIT_AFULL = 7;
    localparam int BIT_DATA_RDY = 6;
    localparam int BIT_AMB_OVF = 5;
    localparam int BIT_PROX = 4;
    localparam int BIT_LED_NC = 3;
    localparam int BIT_TEMP_RDY = 2;
    localparam int BIT_UNDERVOLT = 0;
    localparam logic [7:0] FLAG_IMPL = 8'hfd;
    // control register bits
    localparam int CTL_CLEAR_ON_DATA_READ = 0;
    localparam int CTL_PROX_EN = 1;
    localparam int CTL_LED_NC_EN = 2;
    localparam int CTL_SHUTDOWN = 3;
    // proximity comparison scale
    localparam int PROX_SCALE_SHIFT = 11;
    localparam int ADC_W = 19;
    // proximity-mode sample period
    localparam longint SYS_CLK_HZ = 200000000;
    localparam longint PROX_RATE_HZ = 8;
    localparam longint PROX_PERIOD_CYC = SYS_CLK_HZ / PROX_RATE_HZ;
    typedef enum logic [1:0] {OSIRQ_IDLE, OSIRQ_NORMAL, OSIRQ_PROX} osirq_mode_e;
    typedef struct packed {
        logic afullNext;
        logic samplePushed;
        logic ambientOverflow;
        logic firstExposureValid;
        logic [ADC_W-1:0] firstExposureCode;
        logic sampleEnd;
        logic ledNonCompliant;
        logic tempDone;
        logic underVoltage;
        logic softReset;
    } osirq_events_s;
endpackage

// >>> rtl/osirq_status.sv
// osirq_status: event flags, mask, proximity mode tracking and irq output
// assumes event inputs come from logic on sys_clk; under-voltage is a pin
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
// Functional notes
// - set almost-full flag when next sample would exceed the almost-full threshold.
// - almost-full clears on status read, or on FIFO data read if option set.
// - set data-ready flag whenever a new sample enters the FIFO.
// - data-ready clears on status read, or FIFO data read if option set.
// - set ambient-overflow flag on cancellation saturation; clear on status read.
// - proximity disabled means the LED sequence starts at once.
// - set proximity flag when first exposure crosses threshold; clear on status read.
// - at sample end set LED flag if noncompliant and enabled; status read clears.
// - temperature-ready sets on conversion done; clears on temp read or status read.
// - under-voltage sets flag, never soft reset; clears on status read or shutdown.
// - proximity mode when first reading below 2048 times threshold, else normal.
// - proximity mode samples at 8 Hz, first exposure only, pilot current.
// - proximity flag raised on entry into proximity or normal mode only when a first-exposure reading causes it with proximity enabled.
module osirq_status
    import osirq_pkg::*;
#(
    parameter longint PROX_PERIOD = PROX_PERIOD_CYC
)(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire osirq_events_s events,
    input wire logic undervoltagePin,
    output logic irq,
    output logic sequenceStart,
    output logic proximityMode,
    output logic pilotCurrentSelect,
    output logic firstSlotOnly,
    output logic proxSampleTick,
    output logic fifoDataRead,
    output logic tempDataRead
);
    logic wrStb;
    logic rdStb;
    logic [ADDR_W-1:0] regAddr;
    logic addrValid;
    logic readyW;
    logic [7:0] eventFlags;
    logic [7:0] intMask;
    logic [3:0] control;
    logic [7:0] proximityThreshold;
    osirq_mode_e mode;
    logic uvMeta;
    logic uvSync;
    logic uvPrev;
    logic [7:0] setVec;
    logic [7:0] clrVec;
    logic [7:0] next_eventFlags;
    logic statusRead;
    logic fifoRd;
    logic tempRd;
    logic proxEnable;
    logic belowThreshold;
    logic modeChange;
    logic [ADC_W+PROX_SCALE_SHIFT-1:0] scaledThreshold;
    logic [31:0] proxCount;
    logic [31:0] next_prdata;

    osirq_apb_slave u_apb (
        .sys_clk(sys_clk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pready(readyW),
        .slverr(),
        .wrStb(wrStb),
        .rdStb(rdStb),
        .regAddr(regAddr),
        .addrValid(addrValid)
    );

    always_comb begin
        case (regAddr)
            OFS_EVENT_FLAGS, OFS_INT_MASK, OFS_CONTROL, OFS_PROX_THRESH,
            OFS_MODE_STATUS, OFS_FIFO_DATA, OFS_TEMP_DATA: addrValid = 1'b1;
            default: addrValid = 1'b0;
        endcase
    end

    assign statusRead = rdStb && regAddr == OFS_EVENT_FLAGS;
    assign fifoRd = rdStb && regAddr == OFS_FIFO_DATA;
    assign tempRd = rdStb && regAddr == OFS_TEMP_DATA;
    assign proxEnable = control[CTL_PROX_EN];

    // pin crosses into sys_clk through two flops before use
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            uvMeta <= 1'b0;
            uvSync <= 1'b0;
        end else begin
            uvMeta <= undervoltagePin;
            uvSync <= uvMeta;
        end
    end

    // resets low like the idle pin, so no false edge after reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            uvPrev <= 1'b0;
        end else begin
            uvPrev <= uvSync;
        end
    end

    // threshold scaled by 2048 before comparing with the raw code
    assign scaledThreshold = {{(ADC_W - 8){1'b0}}, proximityThreshold, {PROX_SCALE_SHIFT{1'b0}}};
    assign belowThreshold = {{PROX_SCALE_SHIFT{1'b0}}, events.firstExposureCode}
        < scaledThreshold;

    always_comb begin
        modeChange = 1'b0;
        if (proxEnable && events.firstExposureValid) begin
            if (belowThreshold && mode != OSIRQ_PROX) begin
                modeChange = 1'b1;
            end else if (!belowThreshold && mode != OSIRQ_NORMAL) begin
                modeChange = 1'b1;
            end
        end
    end

    always_comb begin
        setVec = 8'h00;
        setVec[BIT_AFULL] = events.afullNext;
        setVec[BIT_DATA_RDY] = events.samplePushed;
        setVec[BIT_AMB_OVF] = events.ambientOverflow;
        setVec[BIT_PROX] = modeChange;
        setVec[BIT_LED_NC] = events.sampleEnd && events.ledNonCompliant
            && control[CTL_LED_NC_EN];
        setVec[BIT_TEMP_RDY] = events.tempDone;
        // soft reset masks the under-voltage edge
        setVec[BIT_UNDERVOLT] = uvSync && !uvPrev && !events.softReset;
    end

    always_comb begin
        // clear only what the read returned; later arrivals wait for the next read
        clrVec = statusRead ? (prdata[7:0] & FLAG_IMPL) : 8'h00;
        if (fifoRd && control[CTL_CLEAR_ON_DATA_READ]) begin
            clrVec[BIT_AFULL] = 1'b1;
            clrVec[BIT_DATA_RDY] = 1'b1;
        end
        if (tempRd) begin
            clrVec[BIT_TEMP_RDY] = 1'b1;
        end
        if (wrStb && regAddr == OFS_CONTROL && pwdata[CTL_SHUTDOWN]) begin
            clrVec[BIT_UNDERVOLT] = 1'b1;
        end
        // set wins over clear so a same-cycle event is kept
        next_eventFlags = ((eventFlags & ~clrVec) | setVec) & FLAG_IMPL;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            eventFlags <= EVENT_FLAGS_RST;
        end else begin
            eventFlags <= next_eventFlags;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            intMask <= INT_MASK_RST;
        end else if (wrStb && regAddr == OFS_INT_MASK) begin
            intMask <= pwdata[7:0] & FLAG_IMPL;
        end
    end

    // shutdown stays set until software clears it; mode waits in idle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            control <= CONTROL_RST;
        end else if (wrStb && regAddr == OFS_CONTROL) begin
            control <= pwdata[3:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            proximityThreshold <= PROX_THRESH_RST;
        end else if (wrStb && regAddr == OFS_PROX_THRESH) begin
            proximityThreshold <= pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode <= OSIRQ_IDLE;
        end else if (control[CTL_SHUTDOWN]) begin
            mode <= OSIRQ_IDLE;
        end else begin
            case (mode)
                OSIRQ_IDLE: begin
                    if (!proxEnable) begin
                        mode <= OSIRQ_NORMAL;
                    end else if (events.firstExposureValid) begin
                        mode <= belowThreshold ? OSIRQ_PROX : OSIRQ_NORMAL;
                    end
                end
                OSIRQ_NORMAL, OSIRQ_PROX: begin
                    if (!proxEnable) begin
                        mode <= OSIRQ_NORMAL;
                    end else if (events.firstExposureValid) begin
                        mode <= belowThreshold ? OSIRQ_PROX : OSIRQ_NORMAL;
                    end
                end
                default: mode <= OSIRQ_IDLE;
            endcase
        end
    end

    // 8 Hz sample divider, only runs in proximity mode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            proxCount <= 32'h0;
            proxSampleTick <= 1'b0;
        end else if (mode != OSIRQ_PROX) begin
            proxCount <= 32'h0;
            proxSampleTick <= 1'b0;
        end else if (proxCount == 32'(PROX_PERIOD - 1)) begin
            proxCount <= 32'h0;
            proxSampleTick <= 1'b1;
        end else begin
            proxCount <= proxCount + 32'h1;
            proxSampleTick <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            proximityMode <= 1'b0;
            pilotCurrentSelect <= 1'b0;
            firstSlotOnly <= 1'b0;
        end else begin
            proximityMode <= next_proxMode();
            pilotCurrentSelect <= next_proxMode();
            firstSlotOnly <= next_proxMode();
        end
    end

    // one-cycle start pulse on each entry to normal from idle with proximity off
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sequenceStart <= 1'b0;
        end else begin
            sequenceStart <= mode == OSIRQ_IDLE && !proxEnable
                && !control[CTL_SHUTDOWN];
        end
    end

    function automatic logic next_proxMode();
        return mode == OSIRQ_PROX;
    endfunction

    always_comb begin
        next_prdata = 32'h0;
        case (regAddr)
            OFS_EVENT_FLAGS: next_prdata[7:0] = eventFlags;
            OFS_INT_MASK: next_prdata[7:0] = intMask;
            OFS_CONTROL: next_prdata[3:0] = control;
            OFS_PROX_THRESH: next_prdata[7:0] = proximityThreshold;
            OFS_MODE_STATUS: next_prdata[1:0] = mode;
            default: next_prdata = 32'h0;
        endcase
    end

    // read data registered on the wait cycle; stable at the completing edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= (psel && !pwrite) ? next_prdata : 32'h0;
            pready <= psel && penable && !readyW && !pready;
            pslverr <= psel && penable && !readyW && !pready && !addrValid;
        end
    end

    // next flags feed irq so it rises in step with the flag itself
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_eventFlags & intMask);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fifoDataRead <= 1'b0;
            tempDataRead <= 1'b0;
        end else begin
            fifoDataRead <= fifoRd;
            tempDataRead <= tempRd;
        end
    end
endmodule

// >>> testbench/osirq_host.sv
// osirq_host: host side APB master for the sensor irq block
// assumes one sys_clk; requests held until pready is sampled high
`timescale 1ns/1ps
module osirq_host (
    input wire logic sys_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no fixed latency assumed, the bench watchdog bounds this
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// >>> testbench/osirq_status_assertions.sv
// osirq_status_assertions: port checks for the sensor irq block
// assumes bind onto osirq_status, one clock, sync reset
`timescale 1ns/1ps
module osirq_status_assertions
    import osirq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sequenceStart,
    input wire logic proximityMode,
    input wire logic pilotCurrentSelect,
    input wire logic firstSlotOnly,
    input wire logic proxSampleTick,
    input wire logic fifoDataRead,
    input wire logic tempDataRead
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire rdDone = psel && penable && pready && !pwrite && !pslverr;
    property p_ready_req; pready |-> psel && penable ##1 !pready; endproperty
    a_ready_req: assert property (p_ready_req) else $error("stray pready");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    property p_fifo_rd; rdDone && paddr[7:0] == OFS_FIFO_DATA |=> fifoDataRead; endproperty
    a_fifo_rd: assert property (p_fifo_rd) else $error("no fifo read strobe");
    property p_fifo_cause; fifoDataRead |-> $past(rdDone); endproperty
    a_fifo_cause: assert property (p_fifo_cause) else $error("fifo strobe without read");
    property p_temp_rd; rdDone && paddr[7:0] == OFS_TEMP_DATA |=> tempDataRead; endproperty
    a_temp_rd: assert property (p_temp_rd) else $error("no temp read strobe");
    property p_seq; sequenceStart |-> !proximityMode; endproperty
    a_seq: assert property (p_seq) else $error("sequence in proximity mode");
    property p_pilot;
        pilotCurrentSelect == proximityMode && firstSlotOnly == proximityMode;
    endproperty
    a_pilot: assert property (p_pilot) else $error("pilot outputs off mode");
    property p_tick; proxSampleTick |-> proximityMode ##1 !proxSampleTick[*8]; endproperty
    a_tick: assert property (p_tick) else $error("proximity tick misplaced");
endmodule

// >>> testbench/tb.sv
// tb: self-checking bench for osirq_status
// assumes osirq_host as register master and a 200 MHz clock
`timescale 1ns/1ps
module tb;
    import osirq_pkg::*;
    logic sys_clk = 0;
    logic rst = 1;
    logic psel, penable, pwrite, pready, pslverr, irq;
    logic undervoltagePin = 0;
    logic [31:0] paddr, pwdata, prdata, rv;
    logic sequenceStart, proximityMode, pilotCurrentSelect, firstSlotOnly;
    logic proxSampleTick, fifoDataRead, tempDataRead, re;
    osirq_events_s events = '0;
    int errTotal = 0;
    int totalChecks = 0;
    // short period keeps the proximity tick visible in a short run
    osirq_status #(.PROX_PERIOD(10)) u_dut (
        .sys_clk(sys_clk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .events(events),
        .undervoltagePin(undervoltagePin),
        .irq(irq),
        .sequenceStart(sequenceStart),
        .proximityMode(proximityMode),
        .pilotCurrentSelect(pilotCurrentSelect),
        .firstSlotOnly(firstSlotOnly),
        .proxSampleTick(proxSampleTick),
        .fifoDataRead(fifoDataRead),
        .tempDataRead(tempDataRead)
    );
    osirq_host u_host (
        .sys_clk(sys_clk),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr)
    );
    initial forever #2.5 sys_clk = ~sys_clk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        u_host.xfer(1'b0, a, 32'h0, rv, re);
        chk(rv, exp);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rv, re);
    endtask
    task fire;
        @(posedge sys_clk);
        events <= '0;
        repeat (3) @(posedge sys_clk);
    endtask
    task t_reset;
        // start pulse stands for one cycle, one edge after the first edge out of reset
        repeat (2) @(posedge sys_clk);
        chk(sequenceStart, 1);
        rd(OFS_EVENT_FLAGS, 32'h0);
        rd(OFS_INT_MASK, 32'h0);
        u_host.xfer(1'b0, 8'h40, 32'h0, rv, re);
        chk(re, 1);
    endtask
    task t_events;
        events.afullNext <= 1;
        events.ambientOverflow <= 1;
        fire();
        rd(OFS_EVENT_FLAGS, 32'ha0);
        rd(OFS_EVENT_FLAGS, 32'h0);
        events.samplePushed <= 1;
        fire();
        rd(OFS_EVENT_FLAGS, 32'h40);
    endtask
    task t_dataread;
        events.samplePushed <= 1;
        fire();
        rd(OFS_FIFO_DATA, 32'h0);
        rd(OFS_EVENT_FLAGS, 32'h40);
        wr(OFS_CONTROL, 32'h1);
        events.samplePushed <= 1;
        events.afullNext <= 1;
        fire();
        rd(OFS_FIFO_DATA, 32'h0);
        rd(OFS_EVENT_FLAGS, 32'h0);
    endtask
    task t_temp_led;
        events.tempDone <= 1;
        fire();
        rd(OFS_TEMP_DATA, 32'h0);
        rd(OFS_EVENT_FLAGS, 32'h0);
        for (int en = 0; en < 2; en++) begin
            wr(OFS_CONTROL, en * 4);
            events.sampleEnd <= 1;
            events.ledNonCompliant <= 1;
            fire();
            rd(OFS_EVENT_FLAGS, en * 8);
        end
    endtask
    // event lands on the sampling edge, then on the clearing edge of a status read
    task t_same_read;
        for (int d = 2; d < 4; d++) begin
            fork
                rd(OFS_EVENT_FLAGS, 32'h0);
                begin
                    repeat (d) @(posedge sys_clk);
                    events.tempDone <= 1;
                    @(posedge sys_clk);
                    events <= '0;
                end
            join
            rd(OFS_EVENT_FLAGS, 32'h4);
        end
    endtask
    task t_uv_irq;
        wr(OFS_INT_MASK, 32'h1);
        events.softReset <= 1;
        undervoltagePin <= 1;
        repeat (6) @(posedge sys_clk);
        chk(irq, 0);
        undervoltagePin <= 0;
        fire();
        undervoltagePin <= 1;
        repeat (6) @(posedge sys_clk);
        chk(irq, 1);
        wr(OFS_CONTROL, 32'h8);
        repeat (2) @(posedge sys_clk);
        chk(irq, 0);
        wr(OFS_CONTROL, 32'h0);
    endtask
    task t_prox;
        wr(OFS_PROX_THRESH, 32'h1);
        wr(OFS_CONTROL, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk(sequenceStart, 0);
        events.firstExposureValid <= 1;
        events.firstExposureCode <= 19'd2047;
        fire();
        rd(OFS_MODE_STATUS, 32'h2);
        rd(OFS_EVENT_FLAGS, 32'h10);
        repeat (12) @(posedge sys_clk);
        chk(firstSlotOnly, 1);
        events.firstExposureValid <= 1;
        events.firstExposureCode <= 19'd2048;
        fire();
        rd(OFS_MODE_STATUS, 32'h1);
        rd(OFS_EVENT_FLAGS, 32'h10);
        chk(proximityMode, 0);
    endtask
    task reportAndStop;
        if (errTotal == 0 && totalChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 0;
        t_reset();
        t_events();
        t_dataread();
        t_temp_led();
        t_same_read();
        t_uv_irq();
        t_prox();
        reportAndStop();
    end
    initial begin
        #50us;
        errTotal++;
        reportAndStop();
    end
endmodule
bind osirq_status osirq_status_assertions u_chk (
    .sys_clk(sys_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pready(pready),
    .pslverr(pslverr),
    .sequenceStart(sequenceStart),
    .proximityMode(proximityMode),
    .pilotCurrentSelect(pilotCurrentSelect),
    .firstSlotOnly(firstSlotOnly),
    .proxSampleTick(proxSampleTick),
    .fifoDataRead(fifoDataRead),
    .tempDataRead(tempDataRead)
);
